// ### logic/inkjet_nozzle_fire_control.sv
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
// Overview of operation
// - Control strobe rise captures shifted control bits
// - Columns fire only with pulse low, test off
// - Mask wipe high holds latch at zero
// - Test mode forces columns off, enables sources
// - Test source needs mask bit and set-pulse low
// - Test mode low enables row short detection
// - Mask load rise copies shift register to latch
// - Mask bits sampled on shift clock rise
// - Set pulse low fires columns with ones
// - Clear pulse low fires columns with zeros
// - Chip reset low clears mask, control, row counter and ADC shift registers
// - ADC go high starts fresh conversion
// - ADC bit valid at shift clock fall
// - ADC result shifted out, eight bits
// - Test mode: fault flag on open load
// - Normal mode: fault flag on row short
// - Two heads, 13 rows by 16 columns
// - Only one head's rows active
// - Column, source, row, short-detect and fault outputs inhibited during power-up
// - Row scan counter can be disabled
// - Auto-scan makes counter drive row decoder
// - Head choice low A, high B
// - Rows enabled only while head enable low
// - Counter up/down, clear low, step on rise
module inkjet_nozzle_fire_control
  import nozzle_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 chip_reset_n,
  input  wire logic                 control_strobe,
  input  wire logic                 mask_serial_in,
  input  wire logic                 mask_shift_clock,
  input  wire logic                 mask_load,
  input  wire fire_ctl_t            fire_pins,
  input  wire scan_ctl_t            scan_pins,
  input  wire logic                 adc_go,
  input  wire logic                 adc_shift_clock,
  output logic                      adc_serial_out,
  output logic                      nozzle_fault_flag,
  output logic [COLS-1:0]           column_drive,
  output logic [COLS-1:0]           test_source,
  output logic [ROWS-1:0]           row_select_a,
  output logic [ROWS-1:0]           row_select_b,
  output logic                      short_detect_en,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_awaddr,
  input  wire logic                 s_awvalid,
  output logic                      s_awready,
  input  wire logic [31:0]          s_wdata,
  input  wire logic [3:0]           s_wstrb,
  input  wire logic                 s_wvalid,
  output logic                      s_wready,
  output logic [1:0]                s_bresp,
  output logic                      s_bvalid,
  input  wire logic                 s_bready,
  input  wire logic [7:0]           s_araddr,
  input  wire logic                 s_arvalid,
  output logic                      s_arready,
  output logic [31:0]               s_rdata,
  output logic [1:0]                s_rresp,
  output logic                      s_rvalid,
  input  wire logic                 s_rready
);

  // Pin synchronisers
  localparam int NSYNC = 7 + $bits(fire_ctl_t) + $bits(scan_ctl_t);
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= {chip_reset_n, control_strobe, mask_serial_in, mask_shift_clock,
                mask_load, adc_go, adc_shift_clock, fire_pins, scan_pins};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  logic      rst_n_s;
  logic      cstrobe_s;
  logic      sdi_s;
  logic      sclk_s;
  logic      mload_s;
  logic      go_s;
  logic      aclk_s;
  fire_ctl_t fire_s;
  scan_ctl_t scan_s;
  logic      scan_step_prev;
  logic      sclk_prev;
  logic      cstrobe_prev;
  logic      mload_prev;
  logic      aclk_prev;

  assign {rst_n_s, cstrobe_s, sdi_s, sclk_s, mload_s, go_s, aclk_s} = sync2[NSYNC-1 -: 7];
  assign fire_s = sync2[$bits(scan_ctl_t) +: $bits(fire_ctl_t)];
  assign scan_s = sync2[$bits(scan_ctl_t)-1:0];
  assign {cstrobe_prev, sclk_prev, mload_prev} = {prev[NSYNC-2], prev[NSYNC-4], prev[NSYNC-5]};
  assign aclk_prev      = prev[NSYNC-7];
  assign scan_step_prev = prev[1];

  // Pin edge pulses
  logic sclk_rise;
  logic mload_rise;
  logic cstrobe_rise;
  logic adc_shift_clock_rise;
  logic step_rise;

  assign sclk_rise    = sclk_s && !sclk_prev;
  assign mload_rise   = mload_s && !mload_prev;
  assign cstrobe_rise = cstrobe_s && !cstrobe_prev;
  assign adc_shift_clock_rise    = aclk_s && !aclk_prev;
  assign step_rise    = scan_s.scan_step && !scan_step_prev;

  logic chip_clr;
  assign chip_clr = !aresetn || !rst_n_s;

  // Power-up hold
  logic [PWR_W-1:0] pwr_cnt;
  logic             power_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_cnt  <= '0;
      power_ok <= 1'b0;
    end else if (pwr_cnt == PWR_W'(POWERUP_CYCLES - 1)) begin
      power_ok <= 1'b1;
    end else begin
      pwr_cnt <= pwr_cnt + 1'b1;
    end
  end

  // Mask shift register and latch
  logic [COLS-1:0]      mask_shift;
  logic [COLS-1:0]      mask_latch;
  logic [CTRL_BITS-1:0] ctrl_reg;

  always_ff @(posedge aclk) begin
    if (chip_clr) begin
      mask_shift <= '0;
    end else if (sclk_rise) begin
      mask_shift <= {mask_shift[COLS-2:0], sdi_s};
    end
  end

  always_ff @(posedge aclk) begin
    if (chip_clr || fire_s.wipe) begin
      mask_latch <= '0;
    end else if (mload_rise) begin
      mask_latch <= mask_shift;
    end
  end

  always_ff @(posedge aclk) begin
    if (chip_clr) begin
      ctrl_reg <= '0;
    end else if (cstrobe_rise) begin
      ctrl_reg <= mask_shift[CTRL_BITS-1:0];
    end
  end

  // Column drive and test sources
  logic enabled;
  assign enabled = power_ok && !chip_clr;

  always_ff @(posedge aclk) begin
    if (!enabled || fire_s.test_mode) begin
      column_drive <= '0;
    end else begin
      column_drive <= ({COLS{!fire_s.fire_set_n}} & mask_latch)
                    | ({COLS{!fire_s.fire_clr_n}} & ~mask_latch);
    end
  end

  always_ff @(posedge aclk) begin
    if (!enabled || !fire_s.test_mode) begin
      test_source <= '0;
    end else begin
      test_source <= mask_latch & {COLS{!fire_s.fire_set_n}};
    end
  end

  always_ff @(posedge aclk) begin
    short_detect_en <= enabled && !fire_s.test_mode;
  end

  // Row scan counter
  logic [ROW_CNT_W-1:0] row_cnt;
  logic [ROW_CNT_W-1:0] row_idx;

  always_ff @(posedge aclk) begin
    if (chip_clr || (scan_s.auto_scan_enable && !scan_s.scan_clear_n)) begin
      row_cnt <= '0;
    end else if (scan_s.auto_scan_enable && step_rise) begin
      if (scan_s.scan_direction) begin
        row_cnt <= (row_cnt == ROW_CNT_W'(ROWS - 1)) ? '0 : row_cnt + 1'b1;
      end else begin
        row_cnt <= (row_cnt == '0) ? ROW_CNT_W'(ROWS - 1) : row_cnt - 1'b1;
      end
    end
  end

  assign row_idx = scan_s.auto_scan_enable ? row_cnt
                 : {scan_s.dec3, scan_s.scan_direction, scan_s.scan_clear_n, scan_s.scan_step};

  logic [ROWS-1:0] row_onehot;
  always_comb begin
    row_onehot = '0;
    if (row_idx < ROW_CNT_W'(ROWS)) begin
      row_onehot[row_idx] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!enabled || scan_s.head_enable_n) begin
      row_select_a <= '0;
      row_select_b <= '0;
    end else if (!scan_s.head_choice) begin
      row_select_a <= row_onehot;
      row_select_b <= '0;
    end else begin
      row_select_a <= '0;
      row_select_b <= row_onehot;
    end
  end

  // Fault flag from software-fed analog sense bits
  logic [2:0] sense;
  always_ff @(posedge aclk) begin
    if (!enabled) begin
      nozzle_fault_flag <= 1'b0;
    end else if (fire_s.test_mode) begin
      nozzle_fault_flag <= sense[PIN_FAULT_OPEN];
    end else begin
      nozzle_fault_flag <= sense[PIN_FAULT_SHORT];
    end
  end

  // A/D readout
  logic [ADC_BITS-1:0] adc_sample;
  logic [ADC_BITS-1:0] adc_shift;

  always_ff @(posedge aclk) begin
    if (chip_clr) begin
      adc_shift      <= '0;
      adc_serial_out <= 1'b0;
    end else if (go_s) begin
      adc_shift      <= adc_sample;
      adc_serial_out <= adc_sample[ADC_BITS-1];
    end else if (adc_shift_clock_rise) begin
      adc_serial_out <= adc_shift[ADC_BITS-2];
      adc_shift      <= {adc_shift[ADC_BITS-2:0], 1'b0};
    end
  end

  // AXI4-Lite write path
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic        w_held;

  // Registered ready, reopened once the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b0;
    end else if (s_awvalid && s_awready) begin
      s_awready <= 1'b0;
    end else if (!aw_held && !s_bvalid) begin
      s_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_wready <= 1'b0;
    end else if (s_wvalid && s_wready) begin
      s_wready <= 1'b0;
    end else if (!w_held && !s_bvalid) begin
      s_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held    <= 1'b0;
      w_held     <= 1'b0;
      aw_addr    <= '0;
      w_data     <= '0;
      s_bvalid   <= 1'b0;
      s_bresp    <= RESP_OKAY;
      sense      <= '0;
      adc_sample <= '0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data <= s_wdata;
      end
      if (aw_held && w_held) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= RESP_OKAY;
        if (aw_addr == OFS_SENSE) begin
          sense <= w_data[2:0];
        end else if (aw_addr == OFS_ADC) begin
          adc_sample <= w_data[ADC_BITS-1:0];
        end else begin
          s_bresp <= RESP_SLVERR;
        end
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  logic [31:0] status_word;
  assign status_word = {16'h0000, 4'h0, row_cnt, 6'h00, fire_s.test_mode, power_ok};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
    end else if (!s_rvalid) begin
      s_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= '0;
      s_rresp  <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp  <= RESP_OKAY;
      if (s_araddr == OFS_PINS) begin
        s_rdata <= {16'h0000, column_drive};
      end else if (s_araddr == OFS_MASK) begin
        s_rdata <= {mask_shift, mask_latch};
      end else if (s_araddr == OFS_CTRL) begin
        s_rdata <= {24'h000000, ctrl_reg};
      end else if (s_araddr == OFS_STATUS) begin
        s_rdata <= status_word;
      end else if (s_araddr == OFS_ADC) begin
        s_rdata <= {24'h000000, adc_sample};
      end else if (s_araddr == OFS_SENSE) begin
        s_rdata <= {29'h0, sense};
      end else begin
        s_rdata <= '0;
        s_rresp <= RESP_SLVERR;
      end
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule

// ### logic/nozzle_pkg.sv
package nozzle_pkg;

  localparam int COLS        = 16;
  localparam int ROWS        = 13;
  localparam int ADC_BITS    = 8;
  localparam int CTRL_BITS   = 8;
  localparam int ROW_CNT_W   = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_PINS     = 8'h00;
  localparam logic [7:0] OFS_MASK     = 8'h04;
  localparam logic [7:0] OFS_CTRL     = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_ADC      = 8'h10;
  localparam logic [7:0] OFS_SENSE    = 8'h14;

  // Software pin-control register fields
  localparam int PIN_FAULT_OPEN  = 0;
  localparam int PIN_FAULT_SHORT = 1;
  localparam int PIN_SCAN_LOAD   = 2;

  // Status register fields
  localparam int ST_POWER_OK  = 0;
  localparam int ST_TEST_MODE = 1;
  localparam int ST_ROW_LSB   = 8;

  // Power-up hold
  localparam int POWERUP_US     = 10;
  localparam int CLK_MHZ        = 100;
  localparam int POWERUP_CYCLES = POWERUP_US * CLK_MHZ;
  localparam int PWR_W          = 10;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic fire_set_n;
    logic fire_clr_n;
    logic test_mode;
    logic wipe;
  } fire_ctl_t;

  typedef struct packed {
    logic auto_scan_enable;
    logic head_choice;
    logic head_enable_n;
    logic scan_direction;
    logic scan_clear_n;
    logic scan_step;
    logic dec3;
  } scan_ctl_t;

endpackage

// ### sim/nozzle_monitor.sv
`timescale 1ns/1ns
module nozzle_monitor
  import nozzle_pkg::*;
(
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            chip_reset_n,
  input wire fire_ctl_t       fire_pins,
  input wire scan_ctl_t       scan_pins,
  input wire logic [COLS-1:0] column_drive,
  input wire logic [COLS-1:0] test_source,
  input wire logic [ROWS-1:0] row_select_a,
  input wire logic [ROWS-1:0] row_select_b,
  input wire logic            short_detect_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence test_on; fire_pins.test_mode [*5]; endsequence
  sequence pulse_off; (fire_pins.fire_set_n && fire_pins.fire_clr_n) [*5]; endsequence
  fire_gate_a: assert property (pulse_off |-> column_drive == '0)
    else $error("column on without pulse");
  test_cols_a: assert property (test_on |-> column_drive == '0)
    else $error("column on in test mode");
  src_gate_a: assert property ((!fire_pins.test_mode) [*5] |-> test_source == '0)
    else $error("source on outside test");
  short_off_a: assert property (test_on |-> !short_detect_en)
    else $error("short detect in test mode");
  one_head_a: assert property (!((|row_select_a) && (|row_select_b)))
    else $error("both heads active");
  head_off_a: assert property (scan_pins.head_enable_n [*5] |-> {row_select_a, row_select_b} == '0)
    else $error("rows on while disabled");
  head_pick_a: assert property ((!scan_pins.head_choice) [*5] |-> row_select_b == '0)
    else $error("head b on with a chosen");
  chip_rst_a: assert property ((!chip_reset_n) [*5] |-> column_drive == '0)
    else $error("columns on in chip reset");
  power_hold_a: assert property ($rose(aresetn) |-> (column_drive == '0) [*8])
    else $error("columns on at power up");
endmodule

bind inkjet_nozzle_fire_control nozzle_monitor nozzle_monitor_inst (.*);

// ### sim/ctl_model.sv
`timescale 1ns/1ns
module ctl_model (
  output logic      mask_serial_in,
  output logic      mask_shift_clock,
  output logic      mask_load,
  output logic      control_strobe,
  output logic      adc_go,
  output logic      adc_shift_clock,
  input  wire logic adc_serial_out
);
  initial begin
    {mask_serial_in, mask_shift_clock, mask_load, control_strobe, adc_go} = 5'h00;
    adc_shift_clock = 1'b1;
  end
  task automatic send(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      mask_serial_in <= v[i];
      #62 mask_shift_clock <= 1'b1;
      #63 mask_shift_clock <= 1'b0;
    end
    #62 mask_serial_in <= ~mask_serial_in;
  endtask
  task automatic strobe(input bit ld);
    if (ld) mask_load <= 1'b1;
    else control_strobe <= 1'b1;
    #125 mask_load <= 1'b0;
    control_strobe <= 1'b0;
    #125;
  endtask
  task automatic fetch(output logic [7:0] v);
    adc_go <= 1'b1;
    #125 adc_go <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      #62 v = {v[6:0], adc_serial_out};
      adc_shift_clock <= 1'b0;
      #63 adc_shift_clock <= 1'b1;
    end
  endtask
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import nozzle_pkg::*;
  logic            aclk, aresetn, chip_reset_n, nozzle_fault_flag, short_detect_en;
  fire_ctl_t       fire_pins;
  scan_ctl_t       scan_pins;
  logic            mask_serial_in, mask_shift_clock, mask_load, control_strobe;
  logic            adc_go, adc_shift_clock, adc_serial_out;
  logic [COLS-1:0] column_drive, test_source;
  logic [ROWS-1:0] row_select_a, row_select_b;
  logic [7:0]      s_awaddr, s_araddr, g;
  logic [31:0]     s_wdata, s_rdata, q, seed;
  logic [3:0]      s_wstrb;
  logic [1:0]      s_bresp, s_rresp, rs;
  logic            s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic            s_arvalid, s_arready, s_rvalid, s_rready;
  logic [15:0]     sh;
  logic            sq[$];
  int              errors, n_tests, c;
  inkjet_nozzle_fire_control inkjet_nozzle_fire_control_inst (.*);
  ctl_model ctl_model_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, tr, dn;
    @(posedge aclk);
    {s_awaddr, s_araddr, s_wdata} <= {a, a, d};
    {s_awvalid, s_wvalid, s_bready} <= {3{w}};
    {s_arvalid, s_rready} <= {2{!w}};
    dn = 1'b0;
    while (!dn) begin
      @(negedge aclk);
      {ta, tw, tr} = {s_awready, s_wready, s_arready};
      dn = (s_bvalid && s_bready) || (s_rvalid && s_rready);
      {q, rs} = {s_rdata, w ? s_bresp : s_rresp};
      @(posedge aclk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
      if (tr) s_arvalid <= 1'b0;
      if (dn) {s_bready, s_rready} <= 2'b00;
    end
  endtask
  task automatic pins(input fire_ctl_t f, input scan_ctl_t s);
    @(posedge aclk);
    fire_pins <= f;
    scan_pins <= s;
    repeat (6) @(posedge aclk);
  endtask
  initial begin
    #200_000;
    errors++;
    stop_test();
  end
  initial begin
    {aresetn, chip_reset_n, fire_pins, scan_pins} = {2'b01, 4'hc, 7'h10};
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
    {s_wstrb, seed, sh} = {4'hf, 32'h000144f9, 16'h0};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    pins(4'b0000, 7'h00);
    chk("hold", 32'h0, {column_drive, row_select_a});
    pins(4'b1100, 7'h10);
    repeat (POWERUP_CYCLES + 10) @(posedge aclk);
    repeat (3) begin
      q = xs();
      for (int i = 15; i >= 0; i--) sq.push_back(q[i]);
      ctl_model_inst.send(q[15:0]);
      while (sq.size() > 0) sh = {sh[14:0], sq.pop_front()};
      ctl_model_inst.strobe(1'b1);
      ctl_model_inst.strobe(1'b0);
      bus(1'b0, OFS_MASK, 32'h0);
      chk("mask", {sh, sh}, q);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl", {24'h0, sh[7:0]}, q);
      for (int k = 0; k < 4; k++) begin
        pins({k[1:0], 2'b00}, scan_pins);
        chk("cols", {16'h0, (k[1] ? 16'h0 : sh) | (k[0] ? 16'h0 : ~sh)}, column_drive);
        repeat (2) pins(4'b1100, scan_pins);
      end
      pins(4'b0110, scan_pins);
      chk("cols", 32'h0, column_drive);
      chk("src", {16'h0, sh}, test_source);
      pins(4'b0101, scan_pins);
      pins(4'b0100, scan_pins);
      chk("wipe", 32'h0, column_drive);
      pins(4'b1100, scan_pins);
    end
    for (int k = 0; k < 8; k++) begin
      pins({2'b11, k[2], 1'b0}, scan_pins);
      bus(1'b1, OFS_SENSE, {30'h0, k[1:0]});
      repeat (4) @(posedge aclk);
      chk("flag", k[2] ? k[0] : k[1], nozzle_fault_flag);
      chk("sdet", !k[2], short_detect_en);
    end
    for (int k = 0; k < 32; k++) begin
      pins(4'b1100, {1'b0, k[4], 1'b0, k[2:0], k[3]});
      q = (k[3:0] < 13) ? 32'h1 << k[3:0] : 32'h0;
      chk("rowa", k[4] ? 32'h0 : q, row_select_a);
      chk("rowb", k[4] ? q : 32'h0, row_select_b);
    end
    pins(4'b1100, 7'h14);
    chk("rows", 32'h0, {row_select_a, row_select_b});
    pins(4'b1100, 7'h48);
    chk("clr", 32'h1, row_select_a);
    c = 0;
    for (int k = 0; k < 30; k++) begin
      q = xs();
      pins(4'b1100, {3'b100, q[0], 3'b100});
      pins(4'b1100, {3'b100, q[0], 3'b110});
      c = q[0] ? (c + 1) % 13 : (c + 12) % 13;
      chk("scan", 32'h1 << c, row_select_a);
    end
    repeat (3) begin
      c = xs() & 255;
      bus(1'b1, OFS_ADC, c);
      ctl_model_inst.fetch(g);
      chk("adc", c, g);
    end
    bus(1'b0, 8'h40, 32'h0);
    chk("resp", RESP_SLVERR, rs);
    chk("rdat", 32'h0, q);
    chip_reset_n <= 1'b0;
    fire_pins    <= 4'b1000;
    repeat (8) @(posedge aclk);
    chk("rstcol", 32'h0, column_drive);
    fire_pins    <= 4'b1100;
    chip_reset_n <= 1'b1;
    repeat (8) @(posedge aclk);
    bus(1'b0, OFS_MASK, 32'h0);
    chk("mask", 32'h0, q);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", 32'h0, q);
    stop_test();
  end
endmodule
